// *** rtl/boot_remap_address_decoder.v ***
// per-master address decoder with boot source select and remap
// assumes one clock, synchronous reset; bus arbitration sits downstream
// How it works
// - rom always visible at 0x0040_0000
// - boot pin high: rom also at zero
// - host controller window at 0x0050_0000
// - display controller window at 0x0060_0000
// - remap set: sram bank at zero
// - remap held separately per bus master
// - remap clear: boot pin chooses zero memory
// - first megabyte reserved for boot memory
// - boot pin one selects rom
// - boot pin zero selects chip select zero
// - fixed windows always reachable
// - external boot runs on slow clock (this block only raises slow_clock_boot; the clock itself is switched outside)
// - chip select zero resets 16-bit byte-select
// - system peripherals in top window
// - system peripheral slots 256 or 512 bytes
// - user peripherals 16 Kbyte slots
// - external accesses go to slave 3
// - sixteen areas of 256 Mbytes
// - areas 1..8 drive chip selects
// - unused areas give abort response
`timescale 1ns/1ps
`include "boot_remap_consts.vh"

module boot_remap_address_decoder #(
    parameter NUM_MASTERS = 5,  // bus masters, one decoder each
    parameter EXT_CS      = 8   // external chip selects
) (
    // clock and reset
    input  wire                       sys_clk,
    input  wire                       sys_rst,
    // boot strap pin, asynchronous
    input  wire                       boot_source_select_pin,
    // remap control from software, one bit per master
    input  wire [NUM_MASTERS-1:0]     remap_set,
    input  wire [NUM_MASTERS-1:0]     remap_clear,
    // request addresses, one word per master
    input  wire [NUM_MASTERS*32-1:0]  haddr,
    input  wire [NUM_MASTERS-1:0]     hsel_req,
    // decoded slave per master, 3 bits each
    output reg  [NUM_MASTERS*3-1:0]   slave_sel,
    // external chip select one-hot per master
    output reg  [NUM_MASTERS*EXT_CS-1:0] ext_cs_sel,
    // peripheral slot index per master (system or user)
    output reg  [NUM_MASTERS*6-1:0]   periph_slot,
    output reg  [NUM_MASTERS-1:0]     periph_is_system,
    // abort response request per master
    output reg  [NUM_MASTERS-1:0]     abort_resp,
    // status
    output reg  [NUM_MASTERS-1:0]     remap_state,
    output reg                        boot_from_rom,
    output reg                        slow_clock_boot,
    // chip select zero reset configuration
    output reg                        cs0_bus_16bit,
    output reg                        cs0_byte_select,
    output reg                        cs0_strobe_by_cs
);
    wire boot_level;       // clean boot pin level
    reg  boot_captured;    // strap caught after reset release
    reg  capture_pending;  // waits for synchroniser to settle
    reg  [2:0] settle_cnt; // settle count for three-flop chain

    // synchronise the boot strap pin
    pin_sync3 u_boot_sync (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .pin_in    (boot_source_select_pin),
        .level_out (boot_level)
    );

    // capture the strap once after release, then hold until next reset
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            boot_captured   <= 1'b0;
            capture_pending <= 1'b1;
            settle_cnt      <= 3'h0;
        end else if (capture_pending) begin
            // capture only once the synchroniser output shows the pin level
            if (settle_cnt == `BOOT_SETTLE_LAST) begin
                boot_captured   <= boot_level;
                capture_pending <= 1'b0;
            end else begin
                settle_cnt <= settle_cnt + 3'h1;
            end
        end
    end

    // boot status outputs; external boot implies slow clock and cs0 defaults
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            boot_from_rom    <= 1'b0;
            slow_clock_boot  <= 1'b0;
            cs0_bus_16bit    <= `CS0_BUS_16BIT;
            cs0_byte_select  <= `CS0_BYTE_SELECT;
            cs0_strobe_by_cs <= `CS0_STROBE_BY_CS;
        end else begin
            boot_from_rom    <= boot_captured;
            slow_clock_boot  <= ~boot_captured & ~capture_pending;
        end
    end

    // per-master remap flags; set wins over clear
    genvar m;
    generate
        for (m = 0; m < NUM_MASTERS; m = m + 1) begin : g_master
            wire [31:0] addr = haddr[m*32 +: 32];       // this master's address
            wire [3:0]  area = addr[`AREA_MSB:`AREA_LSB];
            wire [7:0]  iwin = addr[`INT_WIN_MSB:`INT_WIN_LSB];
            reg  [2:0]  next_slave;
            reg  [EXT_CS-1:0] next_cs;
            reg  [5:0]  next_slot;
            reg         next_sys;
            reg         next_abort;

            // remap bit, cleared at every reset
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    remap_state[m] <= 1'b0;
                end else if (remap_set[m]) begin
                    remap_state[m] <= 1'b1;
                end else if (remap_clear[m]) begin
                    remap_state[m] <= 1'b0;
                end
            end

            // address decode for this master
            always @* begin
                next_slave = `SLV_NONE;
                next_cs    = {EXT_CS{1'b0}};
                next_slot  = 6'h00;
                next_sys   = 1'b0;
                next_abort = 1'b0;
                if (!hsel_req[m]) begin
                    next_slave = `SLV_NONE;
                end else if (area == `AREA_INTERNAL) begin
                    if (iwin == `INT_WIN_BOOT) begin
                        if (remap_state[m]) begin
                            next_slave = `SLV_SRAM;
                        end else if (boot_captured) begin
                            next_slave = `SLV_ROM;
                        end else begin
                            next_slave = `SLV_EXT;
                            next_cs[0] = 1'b1;
                        end
                    end else if (iwin == `INT_WIN_ROM) begin
                        if (addr < (`ROM_BASE | `ROM_SIZE)) begin
                            next_slave = `SLV_ROM;
                        end else begin
                            next_abort = 1'b1;
                        end
                    end else if (iwin == `INT_WIN_SRAM) begin
                        next_slave = `SLV_SRAM;
                    end else if (iwin == `INT_WIN_HOST) begin
                        next_slave = `SLV_HOST_DISPLAY;
                    end else if (iwin == `INT_WIN_DISPLAY) begin
                        next_slave = `SLV_HOST_DISPLAY;
                    end else begin
                        next_abort = 1'b1;
                    end
                end else if (area >= `AREA_EXT_FIRST && area <= `AREA_EXT_LAST) begin
                    next_slave = `SLV_EXT;
                    next_cs    = {{(EXT_CS-1){1'b0}}, 1'b1} << (area - `AREA_EXT_FIRST);
                end else if (area == `AREA_PERIPH) begin
                    if (addr >= `SYS_PERIPH_BASE) begin
                        next_slave = `SLV_PERIPH;
                        next_sys   = 1'b1;
                        next_slot  = {1'b0, addr[`SYS_SLOT_MSB:`SYS_SLOT_LSB]};
                    end else if (addr >= `USER_PERIPH_BASE && addr <= `USER_PERIPH_LAST) begin
                        next_slave = `SLV_PERIPH;
                        next_slot  = addr[`USER_SLOT_MSB:`USER_SLOT_LSB];
                    end else begin
                        next_abort = 1'b1;
                    end
                end else begin
                    next_abort = 1'b1;
                end
            end

            // registered decode results
            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    slave_sel[m*3 +: 3]          <= `SLV_NONE;
                    ext_cs_sel[m*EXT_CS +: EXT_CS] <= {EXT_CS{1'b0}};
                    periph_slot[m*6 +: 6]        <= 6'h00;
                    periph_is_system[m]          <= 1'b0;
                    abort_resp[m]                <= 1'b0;
                end else begin
                    slave_sel[m*3 +: 3]          <= next_slave;
                    ext_cs_sel[m*EXT_CS +: EXT_CS] <= next_cs;
                    periph_slot[m*6 +: 6]        <= next_slot;
                    periph_is_system[m]          <= next_sys;
                    abort_resp[m]                <= next_abort;
                end
            end
        end
    endgenerate
endmodule // boot_remap_address_decoder

// *** inc/boot_remap_consts.vh ***
// address map constants for the boot remap address decoder
// assumes 32-bit byte addresses on the system bus
`ifndef BOOT_REMAP_CONSTS_VH
`define BOOT_REMAP_CONSTS_VH

// first-level area split: top four address bits
`define AREA_MSB          31
`define AREA_LSB          28
`define AREA_INTERNAL     4'h0
`define AREA_EXT_FIRST    4'h1
`define AREA_EXT_LAST     4'h8
`define AREA_PERIPH       4'hf
// second-level internal split on bits 27:20 (1 Mbyte windows)
`define INT_WIN_MSB       27
`define INT_WIN_LSB       20
`define INT_WIN_BOOT      8'h00
`define INT_WIN_ROM       8'h04
`define INT_WIN_HOST      8'h05
`define INT_WIN_DISPLAY   8'h06
// internal SRAM fixed window (1 Mbyte at 0x0030_0000)
`define INT_WIN_SRAM      8'h03
// rom size in bytes: 32 Kbyte
`define ROM_SIZE          32'h0000_8000
// rom fixed base address
`define ROM_BASE          32'h0040_0000
// strap settle: edges counted after reset release before capture
// three sync flops plus the agree stage need four edges to show the pin
`define BOOT_SETTLE_LAST  3'h4
// system peripheral window 0xffff_ea00 .. 0xffff_ffff
`define SYS_PERIPH_BASE   32'hffff_ea00
// user peripheral window 0xfffa_0000 .. 0xfffc_ffff
`define USER_PERIPH_BASE  32'hfffa_0000
`define USER_PERIPH_LAST  32'hfffc_ffff
// user peripheral slot: 16 Kbyte, index from bits 19:14
`define USER_SLOT_MSB     19
`define USER_SLOT_LSB     14
// system peripheral slot: 256 byte granule index from bits 12:8
`define SYS_SLOT_MSB      12
`define SYS_SLOT_LSB      8
// slave numbers
`define SLV_SRAM          3'h0
`define SLV_ROM           3'h1
`define SLV_HOST_DISPLAY  3'h2
`define SLV_EXT           3'h3
`define SLV_PERIPH        3'h4
`define SLV_NONE          3'h7
// external bus unit reset configuration for chip select zero
`define CS0_BUS_16BIT     1'b1
`define CS0_BYTE_SELECT   1'b1
`define CS0_STROBE_BY_CS  1'b1

`endif

// *** rtl/pin_sync3.v ***
// three-stage synchroniser for a pin level
// assumes the pin is asynchronous to sys_clk; output changes once stages 2 and 3 agree
`timescale 1ns/1ps

module pin_sync3 (
    // clock and reset
    input  wire sys_clk,
    input  wire sys_rst,
    // pin and clean level
    input  wire pin_in,
    output reg  level_out
);
    reg stage1;  // first flop, read only by stage2
    reg stage2;  // second flop
    reg stage3;  // third flop

    // shift chain, level follows when stages 2 and 3 agree
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1    <= 1'b0;
            stage2    <= 1'b0;
            stage3    <= 1'b0;
            level_out <= 1'b0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3) begin
                level_out <= stage3;
            end
        end
    end
endmodule // pin_sync3

// *** tb/bus_master_model.sv ***
// one bus master: drives a request address and a valid level
// assumes the bench calls issue; signals change at the falling edge
`timescale 1ns/1ps
module bus_master_model (
    // clock
    input  wire        sys_clk,
    // request side
    output reg  [31:0] addr,
    output reg         req
);
    // idle at start
    initial begin
        addr = 32'h0000_0000;
        req  = 1'b0;
    end
    // one-cycle request; released address is inverted so stale values never match
    task issue(input [31:0] a);
        begin
            @(negedge sys_clk);
            addr = a;
            req  = 1'b1;
            @(negedge sys_clk);
            req  = 1'b0;
            addr = ~a;
        end
    endtask
endmodule // bus_master_model

// *** tb/boot_remap_checker_sva.sv ***
// port assertions for the decoder, lane of master 0 plus shared status
// assumes one clock and synchronous active-high reset
`timescale 1ns/1ps
module boot_remap_checker #(
    parameter NUM_MASTERS = 5,
    parameter EXT_CS      = 8
) (
    input wire logic                          sys_clk,
    input wire logic                          sys_rst,
    input wire logic [NUM_MASTERS*32-1:0]     haddr,
    input wire logic [NUM_MASTERS-1:0]        hsel_req,
    input wire logic [NUM_MASTERS*3-1:0]      slave_sel,
    input wire logic [NUM_MASTERS*EXT_CS-1:0] ext_cs_sel,
    input wire logic [NUM_MASTERS-1:0]        abort_resp,
    input wire logic [NUM_MASTERS-1:0]        remap_state,
    input wire logic                          boot_from_rom,
    input wire logic                          cs0_bus_16bit,
    input wire logic                          cs0_byte_select,
    input wire logic                          cs0_strobe_by_cs
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // area and boot window of master 0
    wire [3:0] area = haddr[31:28];
    wire       zero = hsel_req[0] && (haddr[31:20] == 12'h000);
    property p_rom; hsel_req[0] && haddr[31:15] == 17'h0_0080 |=> slave_sel[2:0] == 3'h1;
    endproperty
    a_rom: assert property (p_rom) else $error("rom window misdecoded");
    property p_host; hsel_req[0] && haddr[31:20] == 12'h005 |=> slave_sel[2:0] == 3'h2;
    endproperty
    a_host: assert property (p_host) else $error("host window misdecoded");
    property p_disp; hsel_req[0] && haddr[31:20] == 12'h006 |=> slave_sel[2:0] == 3'h2;
    endproperty
    a_disp: assert property (p_disp) else $error("display window misdecoded");
    property p_remap; zero && remap_state[0] |=> slave_sel[2:0] == 3'h0; endproperty
    a_remap: assert property (p_remap) else $error("remapped zero not sram");
    property p_brom; zero && !remap_state[0] && boot_from_rom |=> slave_sel[2:0] == 3'h1;
    endproperty
    a_brom: assert property (p_brom) else $error("rom boot zero misdecoded");
    property p_bext; zero && !remap_state[0] && !boot_from_rom |=> ext_cs_sel[0];
    endproperty
    a_bext: assert property (p_bext) else $error("external boot zero misdecoded");
    property p_ext; hsel_req[0] && area >= 4'h1 && area <= 4'h8 |=> slave_sel[2:0] == 3'h3
        && ext_cs_sel[7:0] == (8'h01 << ($past(area) - 4'h1)); endproperty
    a_ext: assert property (p_ext) else $error("external area misdecoded");
    property p_abort; hsel_req[0] && area >= 4'h9 && area <= 4'he |=> abort_resp[0];
    endproperty
    a_abort: assert property (p_abort) else $error("unused area not aborted");
    property p_clr; $fell(sys_rst) |-> remap_state == '0; endproperty
    a_clr: assert property (p_clr) else $error("remap kept over reset");
    property p_cs0; cs0_bus_16bit && cs0_byte_select && cs0_strobe_by_cs; endproperty
    a_cs0: assert property (p_cs0) else $error("chip select zero config wrong");
    c_remap: cover property (p_remap);
    c_ext: cover property (hsel_req[0] && area == 4'h8);
    c_abort: cover property (abort_resp[0]);
endmodule // boot_remap_checker
bind boot_remap_address_decoder boot_remap_checker #(.NUM_MASTERS(NUM_MASTERS),
    .EXT_CS(EXT_CS)) chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .haddr(haddr),
    .hsel_req(hsel_req), .slave_sel(slave_sel), .ext_cs_sel(ext_cs_sel),
    .abort_resp(abort_resp), .remap_state(remap_state), .boot_from_rom(boot_from_rom),
    .cs0_bus_16bit(cs0_bus_16bit), .cs0_byte_select(cs0_byte_select),
    .cs0_strobe_by_cs(cs0_strobe_by_cs));

// *** tb/boot_remap_address_decoder_tb.sv ***
// self-checking bench for the boot remap decoder with two masters
// assumes master models drive requests at the falling edge
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module boot_remap_address_decoder_tb;
    // stimulus and observed ports
    reg         sys_clk     = 1'b0;
    reg         sys_rst     = 1'b1;
    reg         boot_pin    = 1'b1;
    reg  [1:0]  remap_set   = 2'b00;
    reg  [1:0]  remap_clear = 2'b00;
    wire [63:0] haddr;
    wire [1:0]  hsel_req, periph_is_system, abort_resp, remap_state;
    wire [5:0]  slave_sel;
    wire [15:0] ext_cs_sel;
    wire [11:0] periph_slot;
    wire        boot_from_rom, slow_clock_boot, cs0_a, cs0_b, cs0_c;
    int         err_total = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    always #5 sys_clk = ~sys_clk;
    bus_master_model mst0 (.sys_clk(sys_clk), .addr(haddr[31:0]), .req(hsel_req[0]));
    bus_master_model mst1 (.sys_clk(sys_clk), .addr(haddr[63:32]), .req(hsel_req[1]));
    boot_remap_address_decoder #(.NUM_MASTERS(2), .EXT_CS(8)) uut (.sys_clk(sys_clk),
        .sys_rst(sys_rst), .boot_source_select_pin(boot_pin), .remap_set(remap_set),
        .remap_clear(remap_clear), .haddr(haddr), .hsel_req(hsel_req), .slave_sel(slave_sel),
        .ext_cs_sel(ext_cs_sel), .periph_slot(periph_slot), .periph_is_system(periph_is_system),
        .abort_resp(abort_resp), .remap_state(remap_state), .boot_from_rom(boot_from_rom),
        .slow_clock_boot(slow_clock_boot), .cs0_bus_16bit(cs0_a), .cs0_byte_select(cs0_b),
        .cs0_strobe_by_cs(cs0_c));
    // verdict and end of run
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, err_total);
            if (err_total == 0 && samples_checked > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // reset for five cycles, then wait out strap capture
    // after an external boot the bench, as boot software, leaves the clocks alone:
    // the oscillator, pll, cs0 timing, clock switch order is outside this block
    task do_reset(input pin);
        begin
            @(negedge sys_clk);
            boot_pin = pin;
            sys_rst = 1'b1;
            repeat (5) @(negedge sys_clk);
            sys_rst = 1'b0;
            repeat (8) @(negedge sys_clk);
        end
    endtask
    // one request on master m, then compare its decode
    task dec(input m, input [31:0] a, input [2:0] s, input ab);
        begin
            if (m) mst1.issue(a);
            else mst0.issue(a);
            `CHK("slave_sel", s, slave_sel[m*3 +: 3])
            `CHK("abort_resp", ab, abort_resp[m])
        end
    endtask
    // one-cycle remap control pulse
    task pulse(input [1:0] st, input [1:0] cl);
        begin
            @(negedge sys_clk);
            remap_set = st;
            remap_clear = cl;
            @(negedge sys_clk);
            remap_set = 2'b00;
            remap_clear = 2'b00;
        end
    endtask
    task t_rom_boot;
        begin
            do_reset(1'b1);
            `CHK("boot_from_rom", 1'b1, boot_from_rom)
            dec(0, 32'h0000_0100, 3'h1, 1'b0);
            dec(1, 32'h000F_FFFC, 3'h1, 1'b0);
            dec(0, 32'h0040_7FFC, 3'h1, 1'b0);
            dec(0, 32'h0050_0010, 3'h2, 1'b0);
            dec(1, 32'h0060_0020, 3'h2, 1'b0);
            dec(0, 32'h0030_0000, 3'h0, 1'b0);
            dec(0, 32'h9000_0000, 3'h7, 1'b1);
            dec(0, 32'hE000_0000, 3'h7, 1'b1);
            dec(0, 32'hFFFF_EA00, 3'h4, 1'b0);
            `CHK("periph_slot", 6'h0A, periph_slot[5:0])
            dec(0, 32'hFFFC_C000, 3'h4, 1'b0);
            `CHK("periph_slot", 6'h33, periph_slot[5:0])
            $display("test rom boot done");
        end
    endtask
    task t_ext;
        int i;
        begin
            for (i = 1; i <= 8; i++) begin
                dec(0, {i[3:0], 28'h000_0040}, 3'h3, 1'b0);
                `CHK("ext_cs_sel", 8'h01 << (i - 1), ext_cs_sel[7:0])
            end
            @(negedge sys_clk);
            `CHK("idle slave_sel", 3'h7, slave_sel[2:0])
            $display("test external areas done");
        end
    endtask
    task t_remap;
        begin
            pulse(2'b01, 2'b00);
            `CHK("remap_state", 2'b01, remap_state)
            dec(0, 32'h0000_0000, 3'h0, 1'b0);
            dec(1, 32'h0000_0000, 3'h1, 1'b0);
            pulse(2'b00, 2'b01);
            dec(0, 32'h0000_0040, 3'h1, 1'b0);
            pulse(2'b11, 2'b00);
            do_reset(1'b0);
            `CHK("remap_state", 2'b00, remap_state)
            `CHK("slow_clock_boot", 1'b1, slow_clock_boot)
            `CHK("cs0 config", 3'h7, {cs0_a, cs0_b, cs0_c})
            dec(1, 32'h0000_0200, 3'h3, 1'b0);
            `CHK("ext_cs_sel", 8'h01, ext_cs_sel[15:8])
            $display("test remap done");
        end
    endtask
    // main sequence
    initial begin
        t_rom_boot;
        t_ext;
        t_remap;
        end_sim;
    end
    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total = err_total + 1;
            end_sim;
        end
    end
endmodule // boot_remap_address_decoder_tb
